// ### src/ipc_defines.svh
// Register offsets, field positions, reset values and counts of the parity checker
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// Register indices; the byte address is four times the index
`define IPC_IDX_COUNT 6'h02
`define IPC_IDX_IRQ_EN 6'h03
`define IPC_IDX_IRQ_ST 6'h04
`define IPC_IDX_CONFIG 6'h20

// Fields of the interface configuration register
`define IPC_CFG_MODE_LSB 0
`define IPC_CFG_WIDTH_LSB 2
`define IPC_CFG_LVDS_BIT 5
`define IPC_CFG_QUAD_BIT 6
`define IPC_CFG_BITS 7

// Parity bit of the enable and status registers
`define IPC_PAR_BIT 7

// Reset values
`define IPC_RST_COUNT 8'h00
`define IPC_RST_IRQ_EN 8'h00
`define IPC_RST_IRQ_ST 8'h00
`define IPC_RST_CONFIG 7'h00

// Counts
`define IPC_COUNT_MAX 9'h0ff
`define IPC_FRAME_PERIOD 3'h7

`endif

// ### src/ipc_pkg.sv
// Types and shared parity helper of the parity checker
package ipc_pkg;

   // Parity mode field encodings
   typedef enum logic [1:0] {
      IPC_PM_OFF = 2'h0,
      IPC_PM_IQ = 2'h1,
      IPC_PM_EVEN = 2'h2,
      IPC_PM_ODD = 2'h3
   } ipc_pmode_type;

   // Bus width field encodings
   typedef enum logic [1:0] {
      IPC_BW_4 = 2'h0,
      IPC_BW_8 = 2'h1,
      IPC_BW_16 = 2'h2,
      IPC_BW_32 = 2'h3
   } ipc_width_type;

   // Parity of the low lanes covered at a given bus width
   function automatic logic ipc_par_lo(input logic [31:0] d,
                                       input logic [1:0] w);
      logic [15:0] m;
      case (w)
         IPC_BW_4: m = 16'h000f;
         IPC_BW_8: m = 16'h00ff;
         default: m = 16'hffff;
      endcase
      return ^(d[15:0] & m);
   endfunction

endpackage

// ### src/ipc_link_if.sv
// Link between the data source and the parity-checking device
`timescale 1ns/1ps
`default_nettype none
interface ipc_link_if (
   input wire logic data_clock_out
);
   logic [31:0] data;
   // Upper / lower parity in CMOS, positive / negative pair in LVDS
   logic upper_parity_bit;
   logic lower_parity_bit;
   logic frame_sync;

   modport dev (
      input data_clock_out,
      input data,
      input upper_parity_bit,
      input lower_parity_bit,
      output frame_sync
   );

   modport src (
      input data_clock_out,
      input frame_sync,
      output data,
      output upper_parity_bit,
      output lower_parity_bit
   );
endinterface
`default_nettype wire

// ### src/ipc_parity_eval.sv
// Parity evaluation of one sampled word on one sampling-clock edge
`timescale 1ns/1ps
`default_nettype none
module ipc_parity_eval
   import ipc_pkg::*;
(
   // Sampled word and parity pins
   input wire logic [31:0] data_i,
   input wire logic hi_i,
   input wire logic lo_i,
   // Configuration
   input wire logic [1:0] mode_i,
   input wire logic [1:0] width_i,
   input wire logic lvds_i,
   input wire logic quad_i,
   input wire logic rise_i,
   // Result
   output logic err_o
);
   // Quad upconverter mode pins the bus at 32 bits
   wire logic [1:0] width_eff = quad_i ? IPC_BW_32 : width_i;
   wire logic w32 = (width_eff == IPC_BW_32);
   wire logic odd = (mode_i == IPC_PM_ODD);
   wire logic eo = (mode_i == IPC_PM_EVEN) || odd;
   wire logic iq = (mode_i == IPC_PM_IQ);
   wire logic par_lo = ipc_par_lo(data_i, width_eff);
   wire logic par_hi = ^data_i[31:16];

   wire logic edge_ok = lvds_i ? (!rise_i || w32) : rise_i;

   wire logic cmos_eo = (par_lo ^ lo_i ^ odd) | (w32 & (par_hi ^ hi_i ^ odd));
   wire logic cmos_iq = hi_i | !lo_i;
   // LVDS pair checks the positive line
   wire logic lvds_eo = par_lo ^ hi_i ^ odd;
   // pair values swap per edge; no I/Q at single rate
   wire logic lvds_iq = w32 & (rise_i ? (hi_i | !lo_i) : (!hi_i | lo_i));

   always_comb begin
      err_o = 1'b0;
      if (edge_ok && eo) begin
         err_o = lvds_i ? lvds_eo : cmos_eo;
      end else if (edge_ok && iq) begin
         err_o = lvds_i ? lvds_iq : cmos_iq;
      end
   end
endmodule
`default_nettype wire

// ### src/ipc_device.sv
// Parity checker device: register file, link sampling and error counting
//
// Behaviour
// - two-bit mode: off, I/Q, even, odd
// - I/Q mode expects fixed zero and one
// - source sends valid parity on every edge
// - LVDS double rate only at 32 bits
// - quad mode CMOS: upper 31:16, lower 15:0
// - narrow CMOS: lower checks word, upper ignored
// - DDR rising pair checks rising sixteen lines
// - single rate: falling pair checks data; no I/Q
// - DDR I/Q pair values invert per edge
// - 4-bit bus, one parity per cycle
// - 8-bit error counter saturates at 255
// - writing status bit 7 clears counter
// - enabled parity error sets status, interrupt
// - software reads status on each interrupt
// - writing status bit 7 clears interrupt
// - two parity pins: CMOS bits, LVDS pair
// - LVDS single rate samples on falling edge; CMOS samples on rising edge
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defines.svh"
module ipc_device
   import ipc_pkg::*;
(
   // System clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Shared interrupt pin
   output logic irq_o,
   // Link to the data source
   ipc_link_if.dev link
);
   // System-domain registers
   logic [7:0] count_q, count_d;
   logic [7:0] irq_en_q;
   logic [7:0] irq_st_q, irq_st_d;
   logic [`IPC_CFG_BITS-1:0] cfg_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic irq_q;

   // Link-domain registers
   logic lrst_s1_q, lrst_q;
   logic [`IPC_CFG_BITS-1:0] lcfg_s1_q, lcfg_q;
   logic [31:0] rdata_q, fdata_q;
   logic rhi_q, rlo_q, fhi_q, flo_q;
   logic rvalid_q, fvalid_q;
   logic rtog_q, ftog_q;
   logic [2:0] frm_cnt_q;
   logic frm_q;

   // Crossing back to the system domain
   logic rtog_s1_q, rtog_s2_q, rtog_s3_q;
   logic ftog_s1_q, ftog_s2_q, ftog_s3_q;

   // Bus decode
   wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
   // Writes land on the edge that completes the cycle
   wire logic wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
   wire logic [5:0] idx = wb_adr_i[7:2];
   wire logic hit_count = (idx == `IPC_IDX_COUNT);
   wire logic hit_en = (idx == `IPC_IDX_IRQ_EN);
   wire logic hit_st = (idx == `IPC_IDX_IRQ_ST);
   wire logic hit_cfg = (idx == `IPC_IDX_CONFIG);
   wire logic st_clr = wr && hit_st && wb_dat_i[`IPC_PAR_BIT];

   // Read data selection; unmapped words read zero
   wire logic [31:0] rsel =
      hit_count ? {24'h000000, count_q} :
      hit_en ? {24'h000000, irq_en_q} :
      hit_st ? {24'h000000, irq_st_q} :
      hit_cfg ? {25'h0000000, cfg_q} : 32'h00000000;

   // Configuration fields as seen by the link domain
   wire logic [1:0] l_mode = lcfg_q[`IPC_CFG_MODE_LSB +: 2];
   wire logic [1:0] l_width = lcfg_q[`IPC_CFG_WIDTH_LSB +: 2];
   wire logic l_lvds = lcfg_q[`IPC_CFG_LVDS_BIT];
   wire logic l_quad = lcfg_q[`IPC_CFG_QUAD_BIT];

   // Error events from each sampling edge
   wire logic rerr;
   wire logic ferr;
   wire logic ev_r = rtog_s2_q ^ rtog_s3_q;
   wire logic ev_f = ftog_s2_q ^ ftog_s3_q;
   wire logic ev_any = ev_r || ev_f;
   wire logic [1:0] inc = {1'b0, ev_r} + {1'b0, ev_f};

   // Wishbone answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= req;
         rdat_q <= req ? rsel : 32'h00000000;
      end
   end

   // Software-written control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= `IPC_RST_IRQ_EN;
         cfg_q <= `IPC_RST_CONFIG;
      end else if (wr && hit_en) begin
         irq_en_q <= wb_dat_i[7:0];
      end else if (wr && hit_cfg) begin
         cfg_q <= wb_dat_i[`IPC_CFG_BITS-1:0];
      end
   end

   // saturating count; new errors win over clear
   always_comb begin
      logic [8:0] sum;
      sum = {1'b0, (st_clr ? 8'h00 : count_q)} + {7'h00, inc};
      count_d = (sum > `IPC_COUNT_MAX) ? 8'hff : sum[7:0];
   end

   // status set by enabled error, set wins
   always_comb begin
      irq_st_d = irq_st_q;
      if (st_clr) begin
         irq_st_d[`IPC_PAR_BIT] = 1'b0;
      end
      if (ev_any && irq_en_q[`IPC_PAR_BIT]) begin
         irq_st_d[`IPC_PAR_BIT] = 1'b1;
      end
   end

   // Counter, status and interrupt pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= `IPC_RST_COUNT;
         irq_st_q <= `IPC_RST_IRQ_ST;
         irq_q <= 1'b0;
      end else begin
         count_q <= count_d;
         irq_st_q <= irq_st_d;
         irq_q <= irq_st_d[`IPC_PAR_BIT] && irq_en_q[`IPC_PAR_BIT];
      end
   end

   // Toggle events into the system domain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rtog_s1_q <= 1'b0;
         rtog_s2_q <= 1'b0;
         rtog_s3_q <= 1'b0;
         ftog_s1_q <= 1'b0;
         ftog_s2_q <= 1'b0;
         ftog_s3_q <= 1'b0;
      end else begin
         rtog_s1_q <= rtog_q;
         rtog_s2_q <= rtog_s1_q;
         rtog_s3_q <= rtog_s2_q;
         ftog_s1_q <= ftog_q;
         ftog_s2_q <= ftog_s1_q;
         ftog_s3_q <= ftog_s2_q;
      end
   end

   // Reset and configuration into the link domain
   always_ff @(posedge link.data_clock_out) begin
      lrst_s1_q <= rst_i;
      lrst_q <= lrst_s1_q;
      lcfg_s1_q <= cfg_q;
      lcfg_q <= lcfg_s1_q;
   end

   always_ff @(posedge link.data_clock_out) begin
      if (lrst_q) begin
         rdata_q <= 32'h00000000;
         rhi_q <= 1'b0;
         rlo_q <= 1'b0;
         rvalid_q <= 1'b0;
         rtog_q <= 1'b0;
         frm_cnt_q <= 3'h0;
         frm_q <= 1'b0;
      end else begin
         rdata_q <= link.data;
         rhi_q <= link.upper_parity_bit;
         rlo_q <= link.lower_parity_bit;
         rvalid_q <= 1'b1;
         if (rvalid_q && rerr) begin
            rtog_q <= !rtog_q;
         end
         frm_cnt_q <= frm_cnt_q + 3'h1;
         frm_q <= (frm_cnt_q == `IPC_FRAME_PERIOD);
      end
   end

   always_ff @(negedge link.data_clock_out) begin
      if (lrst_q) begin
         fdata_q <= 32'h00000000;
         fhi_q <= 1'b0;
         flo_q <= 1'b0;
         fvalid_q <= 1'b0;
         ftog_q <= 1'b0;
      end else begin
         fdata_q <= link.data;
         fhi_q <= link.upper_parity_bit;
         flo_q <= link.lower_parity_bit;
         fvalid_q <= 1'b1;
         if (fvalid_q && ferr) begin
            ftog_q <= !ftog_q;
         end
      end
   end

   // Checker for the rising sample
   ipc_parity_eval u_eval_rise (
      .data_i(rdata_q),
      .hi_i(rhi_q),
      .lo_i(rlo_q),
      .mode_i(l_mode),
      .width_i(l_width),
      .lvds_i(l_lvds),
      .quad_i(l_quad),
      .rise_i(1'b1),
      .err_o(rerr)
   );

   // Checker for the falling sample
   ipc_parity_eval u_eval_fall (
      .data_i(fdata_q),
      .hi_i(fhi_q),
      .lo_i(flo_q),
      .mode_i(l_mode),
      .width_i(l_width),
      .lvds_i(l_lvds),
      .quad_i(l_quad),
      .rise_i(1'b0),
      .err_o(ferr)
   );

   // Outputs
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq_o = irq_q;
   assign link.frame_sync = frm_q;
endmodule
`default_nettype wire

// ### src/ipc_source.sv
// Data source end: drives words with parity on both data clock edges
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defines.svh"
module ipc_source
   import ipc_pkg::*;
(
   // User side, synchronous to the data clock
   input wire logic rst_i,
   input wire logic [31:0] word_i,
   input wire logic [1:0] mode_i,
   input wire logic [1:0] width_i,
   input wire logic lvds_i,
   input wire logic quad_i,
   input wire logic flip_i,
   output logic frame_o,
   // Link to the device
   ipc_link_if.src link
);
   // Two flops per signal, one per edge; their XOR is the pin
   logic [31:0] dp_q, dn_q;
   logic hp_q, hn_q, lp_q, ln_q;
   logic frame_q;

   // Parity pins for a word sampled on the given edge
   function automatic logic [1:0] pins(input logic [31:0] d,
                                       input logic rise);
      logic odd;
      logic [1:0] w;
      logic p;
      logic [1:0] r;
      odd = (mode_i == IPC_PM_ODD);
      w = quad_i ? IPC_BW_32 : width_i;
      p = ipc_par_lo(d, w) ^ odd;
      r = 2'h0;
      case (mode_i)
         IPC_PM_EVEN, IPC_PM_ODD: begin
            if (lvds_i) begin
               r = {p, !p};
            end else begin
               r = {(w == IPC_BW_32) & (^d[31:16] ^ odd), p};
            end
         end
         IPC_PM_IQ: begin
            // fixed values, swapped on LVDS falling samples
            r = (lvds_i && !rise) ? 2'h2 : 2'h1;
         end
         default: r = lvds_i ? 2'h1 : 2'h0;
      endcase
      r[0] = r[0] ^ flip_i;
      r[1] = r[1] ^ (flip_i & lvds_i);
      return r;
   endfunction

   logic [1:0] pin_fall;
   logic [1:0] pin_rise;

   // Pin values for both edges; follows every setting the helper reads
   always_comb begin
      pin_fall = pins(word_i, 1'b0);
      pin_rise = pins(word_i, 1'b1);
   end

   // posedge drives the word for the falling sample
   always_ff @(posedge link.data_clock_out) begin
      if (rst_i) begin
         dp_q <= 32'h00000000;
         hp_q <= 1'b0;
         lp_q <= 1'b0;
         frame_q <= 1'b0;
      end else begin
         dp_q <= word_i ^ dn_q;
         hp_q <= pin_fall[1] ^ hn_q;
         lp_q <= pin_fall[0] ^ ln_q;
         frame_q <= link.frame_sync;
      end
   end

   // negedge drives the word for the rising sample
   always_ff @(negedge link.data_clock_out) begin
      if (rst_i) begin
         dn_q <= 32'h00000000;
         hn_q <= 1'b0;
         ln_q <= 1'b0;
      end else begin
         dn_q <= word_i ^ dp_q;
         hn_q <= pin_rise[1] ^ hp_q;
         ln_q <= pin_rise[0] ^ lp_q;
      end
   end

   // Pins
   assign link.data = dp_q ^ dn_q;
   assign link.upper_parity_bit = hp_q ^ hn_q;
   assign link.lower_parity_bit = lp_q ^ ln_q;
   assign frame_o = frame_q;
endmodule
`default_nettype wire

// ### dv/ipc_chk.sv
// Checker of link wire parity and register bus handshake
`timescale 1ns/1ps
`default_nettype none
module ipc_chk (
   // System side
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Link wires and source settings
   input wire logic data_clock_out,
   input wire logic [31:0] data,
   input wire logic upper_parity_bit,
   input wire logic lower_parity_bit,
   input wire logic frame_sync,
   input wire logic src_rst,
   input wire logic [1:0] src_mode,
   input wire logic [1:0] src_width,
   input wire logic src_lvds,
   input wire logic src_quad,
   input wire logic src_flip
);
   logic [7:0] cfg_q;
   logic [1:0] cnt_q;
   // Settled settings and expected parity of the low lanes
   wire logic [7:0] cfg = {src_rst, src_flip, src_mode, src_width,
      src_lvds, src_quad};
   // Wire checks rest while errors are injected on purpose
   wire logic ok = (cfg == cfg_q) && (cnt_q == 2'h3) && !src_flip;
   wire logic w32 = (src_width == 2'h3) || src_quad;
   wire logic [15:0] msk = (w32 || src_width == 2'h2) ? 16'hffff :
      ((src_width == 2'h1) ? 16'h00ff : 16'h000f);
   wire logic eo = ok && src_mode[1];
   wire logic iq = ok && (src_mode == 2'h1);
   wire logic par = ^(data[15:0] & msk) ^ src_mode[0];
   // Link cycles since the last settings change
   always_ff @(posedge data_clock_out) begin
      cfg_q <= cfg;
      cnt_q <= (cfg != cfg_q) ? 2'h0 :
         ((cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1);
   end
   property p_cmos_lo;
      @(posedge data_clock_out) disable iff (src_rst)
      eo && !src_lvds |-> lower_parity_bit == par;
   endproperty
   a_cmos_lo: assert property (p_cmos_lo)
      else $error("cmos lower parity wrong");
   property p_cmos_hi;
      @(posedge data_clock_out) disable iff (src_rst)
      eo && !src_lvds && w32 |->
         upper_parity_bit == (^data[31:16] ^ src_mode[0]);
   endproperty
   a_cmos_hi: assert property (p_cmos_hi)
      else $error("cmos upper parity wrong");
   property p_cmos_iq;
      @(posedge data_clock_out) disable iff (src_rst)
      iq && !src_lvds |-> !upper_parity_bit && lower_parity_bit;
   endproperty
   a_cmos_iq: assert property (p_cmos_iq)
      else $error("cmos iq constants wrong");
   property p_lvds_rise;
      @(posedge data_clock_out) disable iff (src_rst)
      eo && src_lvds && w32 |-> upper_parity_bit == par;
   endproperty
   a_lvds_rise: assert property (p_lvds_rise)
      else $error("rising pair parity wrong");
   property p_lvds_fall;
      @(negedge data_clock_out) disable iff (src_rst)
      eo && src_lvds |-> upper_parity_bit == par;
   endproperty
   a_lvds_fall: assert property (p_lvds_fall)
      else $error("falling pair parity wrong");
   property p_iq_rise;
      @(posedge data_clock_out) disable iff (src_rst)
      iq && src_lvds && w32 |-> !upper_parity_bit && lower_parity_bit;
   endproperty
   a_iq_rise: assert property (p_iq_rise)
      else $error("rising iq pair wrong");
   property p_iq_fall;
      @(negedge data_clock_out) disable iff (src_rst)
      iq && src_lvds && w32 |-> upper_parity_bit && !lower_parity_bit;
   endproperty
   a_iq_fall: assert property (p_iq_fall)
      else $error("falling iq pair wrong");
   property p_frame;
      @(posedge data_clock_out) disable iff (src_rst)
      $rose(frame_sync) |=> !frame_sync [*7] ##1 frame_sync;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame sync period wrong");
   property p_ack_req;
      @(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_req: assert property (p_ack_req)
      else $error("bus request not answered");
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("bus answer longer than one cycle");
endmodule
`default_nettype wire

// ### dv/tb.sv
// Bench joining source and device over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'b0, dclk = 1'b0, rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, word_i = 32'h0, wb_dat_o;
   logic wb_ack_o, irq_o, src_frame, frm_d;
   logic src_rst = 1'b1, src_lvds = 1'b0, src_quad = 1'b0, src_flip = 1'b0;
   logic [1:0] src_mode = 2'h0, src_width = 2'h0;
   logic [9:0] t;
   logic [9:0] tab [8] = '{10'h186, 10'h181, 10'h088, 10'h22f,
      10'h2ad, 10'h1aa, 10'h0a5, 10'h1c3};
   int num_errors = 0, cmp_count = 0, i, k, e;
   logic [31:0] exp_q [$];
   string nm_q [$];
   // Clocks: system 25 ns, link 32 ns at an odd phase
   always #12.5 clk_i = ~clk_i;
   initial begin
      #3.3;
      forever #16 dclk = ~dclk;
   end
   ipc_link_if lnk (.data_clock_out(dclk));
   ipc_device ipc_device_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .irq_o, .link(lnk.dev));
   ipc_source ipc_source_inst (.rst_i(src_rst), .word_i, .mode_i(src_mode),
      .width_i(src_width), .lvds_i(src_lvds), .quad_i(src_quad),
      .flip_i(src_flip), .frame_o(src_frame), .link(lnk.src));
   ipc_chk ipc_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
      .data_clock_out(dclk), .data(lnk.data),
      .upper_parity_bit(lnk.upper_parity_bit),
      .lower_parity_bit(lnk.lower_parity_bit), .frame_sync(lnk.frame_sync),
      .src_rst, .src_mode, .src_width, .src_lvds, .src_quad, .src_flip);
   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Classic single bus cycle, held until the answer
   task automatic wb(input logic we, input logic [7:0] a, d,
      input logic [3:0] s);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20) begin
         num_errors++;
         tally_and_finish();
      end
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input string nm);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      wb(1'b0, a, 8'h00, 4'hf);
   endtask
   task automatic wr(input logic [7:0] a, d);
      wb(1'b1, a, d, 4'h1);
   endtask
   // Same settings on both ends, then let the link settle
   task automatic setup(input logic [6:0] c);
      wr(8'h80, {1'b0, c});
      @(posedge dclk);
      src_mode <= c[1:0];
      src_width <= c[3:2];
      src_lvds <= c[5];
      src_quad <= c[6];
      repeat (6) @(posedge dclk);
   endtask
   // Read answers against the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && wb_cyc_i) begin
         if (exp_q.size() == 0) check("stray read", 32'h1, 32'h0);
         else check(nm_q.pop_front(), wb_dat_o, exp_q.pop_front());
      end
   end
   // Random words on every link cycle
   always @(posedge dclk) word_i <= $urandom;
   // Source copy of the frame mark, one link cycle late
   always @(posedge dclk) begin
      if (src_rst === 1'b0) begin
         check("frame copy", {31'h0, src_frame}, {31'h0, frm_d});
      end
      frm_d <= lnk.frame_sync;
   end
   initial begin
      void'($urandom(71967));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge dclk);
      src_rst <= 1'b0;
      // Reset values, lane select, read-only and unmapped places
      rd(8'h08, 32'h0, "count");
      rd(8'h0c, 32'h0, "enable");
      rd(8'h10, 32'h0, "status");
      rd(8'h80, 32'h0, "config");
      wb(1'b1, 8'h0c, 8'h5a, 4'h0);
      rd(8'h0c, 32'h0, "enable no lane");
      wr(8'h0c, 8'ha5);
      rd(8'h0c, 32'ha5, "enable");
      wr(8'h08, 8'h55);
      rd(8'h08, 32'h0, "count ro");
      wr(8'h44, 8'hff);
      rd(8'h44, 32'h0, "unmapped");
      wr(8'h80, 8'h6b);
      rd(8'h80, 32'h6b, "config");
      $display("T1 registers done");
      // Clean traffic in every mode, width and line kind
      for (i = 0; i < 32; i++) begin
         setup({1'b0, i[4], 1'b0, i[3:0]});
         wr(8'h10, 8'h80);
         repeat (8) @(posedge dclk);
         rd(8'h08, 32'h0, "clean count");
      end
      $display("T2 clean sweep done");
      // Injected errors per case, last pass saturates
      for (i = 0; i < 9; i++) begin
         t = tab[i % 8];
         k = (i == 8) ? 300 : $urandom_range(12, 1);
         setup(t[6:0]);
         wr(8'h0c, {t[7], 7'h0});
         wr(8'h10, 8'h80);
         @(posedge dclk);
         src_flip <= 1'b1;
         repeat (k) @(posedge dclk);
         src_flip <= 1'b0;
         repeat (10) @(posedge dclk);
         e = t[9:8] * k;
         if (e > 255) e = 255;
         rd(8'h08, e, "count");
         rd(8'h10, (t[7] && e != 0) ? 32'h80 : 32'h0, "status");
         check("irq", {31'h0, irq_o}, {31'h0, t[7] && e != 0});
         wr(8'h10, 8'h80);
         rd(8'h08, 32'h0, "count cleared");
         rd(8'h10, 32'h0, "status cleared");
         check("irq cleared", {31'h0, irq_o}, 32'h0);
      end
      $display("T3 error injection done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
